/* File: pda_arbiter.sv */
// Overview of operation
// - Over-charge holds off over-discharge detection
// - Over-discharge resumes after over-charge if persisting
// - Over-discharge after over-charge: no stand-by, pull-up
// - Over-charge first: load-sense node released
// - Over-charge beats later over-current; parallel otherwise
// - Over-current first: pull node to ground
// - Over-discharge beats later over-current; parallel otherwise
// - Over-discharge after over-current: pull-up, stand-by
// - Over-discharge first: pull-up and stand-by
// - Short-circuit detection is always independent
// - Excessive charger blocked during discharge faults
// - Excessive charger delay starts after discharge high
// - Over-charge delay elapsed drives charge gate low
// - Over-discharge delay elapsed drives discharge gate low
// - Current fault released by node low, delayed
// - Test pin shortens only counter delays
`timescale 1ns/10ps
`default_nettype none
`include "pda_consts.svh"

module pda_arbiter (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic test_mode, // Test pin, high shortens
   input wire logic ovc_cmp, // Cell at/above over-charge level
   input wire logic ovc_rel_cmp, // Both cells at/below release level
   input wire logic ovd_cmp, // Cell at/below over-discharge level
   input wire logic ocur_cmp, // Node at/above over-current level
   input wire logic short_cmp, // Node at/above short level
   input wire logic xchg_cmp, // Node at/below charger-excess level
   input wire logic wake_cmp, // Node at/below stand-by release
   output logic chg_gate, // Charge gate, high = on
   output logic dis_gate, // Discharge gate, high = on
   output pda_pkg::pda_pull_t pull_state, // Load-sense pull
   output logic standby // Stand-by entered
);
   // Fault state flags
   logic ovc_reg; // Over-charge state
   logic ovd_reg; // Over-discharge state
   logic cur_reg; // Over-current or short state
   logic xchg_reg; // Excessive charger state
   logic ovc_first_reg; // Over-charge preceded over-discharge
   logic cur_first_reg; // Current fault preceded over-charge
   logic chg_gate_reg;
   logic dis_gate_reg;
   logic standby_reg;
   pda_pkg::pda_pull_t pull_reg;

   // Limits
   logic [`PDA_CNT_W-1:0] l_ovc_det, l_ovc_rel, l_ovd_det, l_ovd_rel;
   logic [`PDA_CNT_W-1:0] l_cur_det, l_cur_rel, l_x_det, l_x_rel;
   logic [`PDA_CNT_W-1:0] l_short;

   pda_limits u_limits (
      .test_mode(test_mode),
      .ovc_det(l_ovc_det),
      .ovc_rel(l_ovc_rel),
      .ovd_det(l_ovd_det),
      .ovd_rel(l_ovd_rel),
      .ocur_det(l_cur_det),
      .ocur_rel(l_cur_rel),
      .xchg_det(l_x_det),
      .xchg_rel(l_x_rel),
      .short_det(l_short)
   );

   // Qualifying conditions for each delay counter
   localparam int NDLY = 9;
   logic [NDLY-1:0] cond;
   logic [NDLY-1:0] done;
   logic [`PDA_CNT_W-1:0] lim [NDLY];

   // Over-discharge held off during over-charge detection
   wire ovd_allow = !(ovc_cmp && !ovc_reg);
   // Over-current interrupted once a voltage fault is entered
   wire cur_allow = !ovc_reg && !ovd_reg;
   // Excessive charger blocked while discharge gate low
   wire x_allow = dis_gate_reg && !ovd_reg && !cur_reg;

   assign cond[0] = ovc_cmp && !ovc_reg;
   assign cond[1] = ovc_reg && ovc_rel_cmp;
   assign cond[2] = ovd_cmp && !ovd_reg && ovd_allow;
   assign cond[3] = ovd_reg && !ovd_cmp && !standby_reg;
   assign cond[4] = ocur_cmp && !cur_reg && cur_allow;
   assign cond[5] = cur_reg && !ocur_cmp;
   assign cond[6] = xchg_cmp && !xchg_reg && x_allow;
   assign cond[7] = xchg_reg && !xchg_cmp;
   // Short path ignores all other states
   assign cond[8] = short_cmp && !cur_reg;

   assign lim[0] = l_ovc_det;
   assign lim[1] = l_ovc_rel;
   assign lim[2] = l_ovd_det;
   assign lim[3] = l_ovd_rel;
   assign lim[4] = l_cur_det;
   assign lim[5] = l_cur_rel;
   assign lim[6] = l_x_det;
   assign lim[7] = l_x_rel;
   assign lim[8] = l_short;

   // One delay counter per detection and release
   genvar gi;
   generate
      for (gi = 0; gi < NDLY; gi++) begin : g_dly
         pda_delay u_dly (
            .sys_clk(sys_clk),
            .rst(rst),
            .cond(cond[gi]),
            .limit(lim[gi]),
            .done(done[gi])
         );
      end
   endgenerate

   // Event decode
   wire ovc_set = done[0];
   wire ovc_clr = done[1];
   wire ovd_set = done[2];
   wire ovd_clr = done[3];
   wire cur_set = done[4] || done[8];
   wire cur_clr = done[5];
   wire x_set = done[6];
   wire x_clr = done[7];

   // Over-discharge entry goes to stand-by unless over-charge led
   wire ovd_sb = !ovc_reg && !ovc_first_reg;

   // Next-state logic
   logic ovc_next, ovd_next, cur_next, xchg_next;
   logic ovc_first_next, cur_first_next, standby_next;
   pda_pkg::pda_pull_t pull_next;

   always_comb begin
      ovc_next = ovc_reg;
      ovd_next = ovd_reg;
      cur_next = cur_reg;
      xchg_next = xchg_reg;
      ovc_first_next = ovc_first_reg;
      cur_first_next = cur_first_reg;
      standby_next = standby_reg;
      // Over-charge
      if (ovc_set) begin
         ovc_next = 1'b1;
         cur_first_next = cur_reg;
      end else if (ovc_clr) begin
         ovc_next = 1'b0;
         cur_first_next = 1'b0;
      end
      // Over-discharge
      if (ovd_set) begin
         ovd_next = 1'b1;
         ovc_first_next = ovc_reg;
         standby_next = ovd_sb;
      end else if (ovd_clr) begin
         ovd_next = 1'b0;
         ovc_first_next = 1'b0;
      end
      // Charger wakes from stand-by
      if (standby_reg && wake_cmp) begin
         standby_next = 1'b0;
      end
      // Current faults, including short
      if (cur_set) begin
         cur_next = 1'b1;
      end else if (cur_clr) begin
         cur_next = 1'b0;
      end
      // Excessive charger
      if (x_set) begin
         xchg_next = 1'b1;
      end else if (x_clr || !x_allow) begin
         xchg_next = 1'b0;
      end
   end

   // Pull selection by priority of entry order
   always_comb begin
      if (ovd_next) begin
         pull_next = pda_pkg::PDA_PULL_VDD;
      end else if (ovc_next && !cur_first_next) begin
         pull_next = pda_pkg::PDA_PULL_OFF;
      end else if (cur_next) begin
         pull_next = pda_pkg::PDA_PULL_VSS;
      end else begin
         pull_next = pda_pkg::PDA_PULL_OFF;
      end
   end

   // State registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ovc_reg <= 1'b0;
         ovd_reg <= 1'b0;
         cur_reg <= 1'b0;
         xchg_reg <= 1'b0;
         ovc_first_reg <= 1'b0;
         cur_first_reg <= 1'b0;
         standby_reg <= 1'b0;
         pull_reg <= pda_pkg::PDA_PULL_OFF;
         chg_gate_reg <= 1'b1;
         dis_gate_reg <= 1'b1;
      end else begin
         ovc_reg <= ovc_next;
         ovd_reg <= ovd_next;
         cur_reg <= cur_next;
         xchg_reg <= xchg_next;
         ovc_first_reg <= ovc_first_next;
         cur_first_reg <= cur_first_next;
         standby_reg <= standby_next;
         pull_reg <= pull_next;
         chg_gate_reg <= !(ovc_next || xchg_next);
         dis_gate_reg <= !(ovd_next || cur_next);
      end
   end

   assign chg_gate = chg_gate_reg;
   assign dis_gate = dis_gate_reg;
   assign pull_state = pull_reg;
   assign standby = standby_reg;

   // Checks
   a_ovc_gate_low: assert property (@(posedge sys_clk) disable iff (rst)
      done[0] |=> !chg_gate) else $error("charge gate not low");
   a_ovd_gate_low: assert property (@(posedge sys_clk) disable iff (rst)
      done[2] |=> !dis_gate) else $error("discharge gate not low");
   a_ovd_held_off: assert property (@(posedge sys_clk) disable iff (rst)
      (ovc_cmp && !ovc_reg) |-> !cond[2]) else $error("ovd not held");
   a_ovc_first_nosb: assert property (@(posedge sys_clk) disable iff (rst)
      (done[2] && ovc_reg) |=> !standby && pull_state == pda_pkg::PDA_PULL_VDD)
      else $error("standby after ovc");
   a_ovd_first_sb: assert property (@(posedge sys_clk) disable iff (rst)
      (done[2] && !ovc_reg && !ovc_first_reg && !wake_cmp) |=> standby)
      else $error("no standby");
   a_cur_pull_vss: assert property (@(posedge sys_clk) disable iff (rst)
      (cur_reg && !ovc_reg && !ovd_reg) |-> pull_state ==
      pda_pkg::PDA_PULL_VSS) else $error("pull not vss");
   a_cur_blocked: assert property (@(posedge sys_clk) disable iff (rst)
      (ovc_reg || ovd_reg) |-> !cond[4]) else $error("ocur not off");
   a_xchg_blocked: assert property (@(posedge sys_clk) disable iff (rst)
      !dis_gate |-> !cond[6]) else $error("xchg not blocked");
   a_cur_release: assert property (@(posedge sys_clk) disable iff (rst)
      done[5] |=> !cur_reg) else $error("no release");

   // Over-charge entered first leaves the node released
   a_ovc_first_off: assert property (@(posedge sys_clk) disable iff (rst)
      (ovc_reg && !cur_first_reg && !ovd_reg) |->
      pull_state == pda_pkg::PDA_PULL_OFF) else $error("node not off");
   // Over-discharge after a current fault goes to stand-by
   a_cur_then_sb: assert property (@(posedge sys_clk) disable iff (rst)
      (done[2] && cur_reg && !ovc_reg) |=> standby &&
      pull_state == pda_pkg::PDA_PULL_VDD) else $error("no sb");
   // Short detection always enters the current fault
   a_short_indep: assert property (@(posedge sys_clk) disable iff (rst)
      done[8] |=> cur_reg && !dis_gate) else $error("short lost");
   // Excessive charger state dropped during discharge faults
   a_xchg_supp: assert property (@(posedge sys_clk) disable iff (rst)
      (ovd_reg || cur_reg) |=> !xchg_reg) else $error("xchg kept");
   // Held-off over-discharge count resumes once over-charge entered
   a_ovd_resume: assert property (@(posedge sys_clk) disable iff (rst)
      (ovc_reg && ovd_cmp && !ovd_reg) |-> cond[2])
      else $error("ovd not resumed");
   // Over-charge count keeps running under a current fault
   a_ovc_parallel: assert property (@(posedge sys_clk) disable iff (rst)
      (cur_reg && ovc_cmp && !ovc_reg) |-> cond[0])
      else $error("ovc stopped");
   // Over-discharge count keeps running under a current fault
   a_ovd_parallel: assert property (@(posedge sys_clk) disable iff (rst)
      (cur_reg && ovd_cmp && !ovd_reg && !ovc_cmp) |-> cond[2])
      else $error("ovd stopped");
   // Test pin shortens counter delays, never the short delay
   a_test_scaled: assert property (@(posedge sys_clk) disable iff (rst)
      test_mode |-> l_ovc_det == `PDA_CNT_W'(
      (`PDA_OVC_DLY_US * `PDA_CLK_MHZ) >> `PDA_TEST_SHIFT))
      else $error("ovc delay not short");
   a_short_fixed: assert property (@(posedge sys_clk) disable iff (rst)
      l_short == `PDA_CNT_W'(`PDA_SHORT_DLY_US * `PDA_CLK_MHZ))
      else $error("short delay changed");
   // Interrupted condition restarts the over-discharge count
   a_ovd_restart: assert property (@(posedge sys_clk) disable iff (rst)
      !cond[2] |=> !done[2]) else $error("count kept");

   c_ovc_entry: cover property (@(posedge sys_clk) disable iff (rst)
      $fell(chg_gate));
   c_ovd_standby: cover property (@(posedge sys_clk) disable iff (rst)
      $rose(standby));
   c_cur_then_ovd: cover property (@(posedge sys_clk) disable iff (rst)
      cur_reg ##1 (cur_reg && ovd_reg));
   c_short_fault: cover property (@(posedge sys_clk) disable iff (rst)
      done[8]);
   // Over-discharge entered while over-charge state stands
   c_ovc_then_ovd: cover property (@(posedge sys_clk) disable iff (rst)
      done[2] && ovc_reg);
endmodule

`default_nettype wire

/* File: pda_consts.svh */
`ifndef PDA_CONSTS_SVH
`define PDA_CONSTS_SVH

// Delay counter width, wide enough for the longest normal delay
`define PDA_CNT_W 26
// Delay times in microseconds (plain defaults)
`define PDA_OVC_DLY_US 1000000
`define PDA_OVC_REL_US 16000
`define PDA_OVD_DLY_US 100000
`define PDA_OVD_REL_US 1000
`define PDA_OCUR_DLY_US 10000
`define PDA_OCUR_REL_US 1000
`define PDA_XCHG_DLY_US 8000
`define PDA_XCHG_REL_US 2000
`define PDA_SHORT_DLY_US 300
// Clock rate in MHz
`define PDA_CLK_MHZ 50
// Test-mode shortening shift, keeps test runs short
`define PDA_TEST_SHIFT 12

`endif

/* File: pda_pkg.sv */
package pda_pkg;
   // Load-sense node pull state
   typedef enum logic [1:0] {
      PDA_PULL_OFF,
      PDA_PULL_VDD,
      PDA_PULL_VSS
   } pda_pull_t;
endpackage

/* File: pda_delay.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pda_consts.svh"

// Qualified delay counter: done after cond held for limit cycles
module pda_delay (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic cond,
   input wire logic [`PDA_CNT_W-1:0] limit,
   output logic done
);
   logic [`PDA_CNT_W-1:0] cnt_reg; // Elapsed cycles
   wire at_limit = (cnt_reg >= limit);

   // Count while cond holds, restart when it drops
   always_ff @(posedge sys_clk) begin
      if (rst || !cond) begin
         cnt_reg <= '0;
      end else if (!at_limit) begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   assign done = cond && at_limit;
endmodule

`default_nettype wire

/* File: pda_limits.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pda_consts.svh"

// Delay limits in cycles, all but the short delay shortened in test mode
module pda_limits (
   input wire logic test_mode,
   output logic [`PDA_CNT_W-1:0] ovc_det,
   output logic [`PDA_CNT_W-1:0] ovc_rel,
   output logic [`PDA_CNT_W-1:0] ovd_det,
   output logic [`PDA_CNT_W-1:0] ovd_rel,
   output logic [`PDA_CNT_W-1:0] ocur_det,
   output logic [`PDA_CNT_W-1:0] ocur_rel,
   output logic [`PDA_CNT_W-1:0] xchg_det,
   output logic [`PDA_CNT_W-1:0] xchg_rel,
   output logic [`PDA_CNT_W-1:0] short_det
);
   // Counter-timed delay scaling
   function automatic logic [`PDA_CNT_W-1:0] scale(input integer us,
                                                  input logic tm);
      logic [`PDA_CNT_W-1:0] c;
      c = `PDA_CNT_W'(us * `PDA_CLK_MHZ);
      if (tm) begin
         c = c >> `PDA_TEST_SHIFT;
      end
      if (c == '0) begin
         c = `PDA_CNT_W'(1);
      end
      return c;
   endfunction

   assign ovc_det = scale(`PDA_OVC_DLY_US, test_mode);
   assign ovc_rel = scale(`PDA_OVC_REL_US, test_mode);
   assign ovd_det = scale(`PDA_OVD_DLY_US, test_mode);
   assign ovd_rel = scale(`PDA_OVD_REL_US, test_mode);
   assign ocur_det = scale(`PDA_OCUR_DLY_US, test_mode);
   assign ocur_rel = scale(`PDA_OCUR_REL_US, test_mode);
   assign xchg_det = scale(`PDA_XCHG_DLY_US, test_mode);
   assign xchg_rel = scale(`PDA_XCHG_REL_US, test_mode);
   // Short delay is counter-timed too, but never shortened
   assign short_det = scale(`PDA_SHORT_DLY_US, 1'b0);
endmodule

`default_nettype wire

/* File: pda_pack_model.sv */
`timescale 1ns/10ps
`default_nettype none

// Pack model: cells, charger, load and switches as comparator levels
module pda_pack_model #(
   parameter int OVC_MV = 4300, // Over-charge level
   parameter int REL_MV = 4100, // Over-charge release level
   parameter int OVD_MV = 2500, // Over-discharge level
   parameter int OCUR_MV = 200, // Over-current level on node
   parameter int SHORT_MV = 1000, // Short level on node
   parameter int XCHG_MV = -800, // Excessive charger level
   parameter int WAKE_MV = -50 // Stand-by release level
) (
   input wire logic signed [15:0] cell_a_mv,
   input wire logic signed [15:0] cell_b_mv,
   input wire logic [1:0] load_sel, // 0 none, 1 heavy, 2 short
   input wire logic [1:0] chgr_sel, // 0 none, 1 normal, 2 excessive
   input wire logic dis_gate,
   input wire pda_pkg::pda_pull_t pull_state,
   output logic ovc_cmp,
   output logic ovc_rel_cmp,
   output logic ovd_cmp,
   output logic ocur_cmp,
   output logic short_cmp,
   output logic xchg_cmp,
   output logic wake_cmp
);
   int node_mv; // Load-sense node voltage

   // Charger drags node below ground, load or pull-up lifts it
   always_comb begin
      if (chgr_sel == 2'h2) begin
         node_mv = -900;
      end else if (chgr_sel == 2'h1) begin
         node_mv = -100;
      end else if (load_sel != 2'h0) begin
         // Open switch lets the load pull node to pack level
         node_mv = (dis_gate && load_sel == 2'h1) ? 300 : 1500;
      end else if (pull_state == pda_pkg::PDA_PULL_VDD) begin
         node_mv = 3000;
      end else begin
         node_mv = 0;
      end
   end

   // Comparator levels
   assign ovc_cmp = cell_a_mv >= OVC_MV || cell_b_mv >= OVC_MV;
   assign ovc_rel_cmp = cell_a_mv <= REL_MV && cell_b_mv <= REL_MV;
   assign ovd_cmp = cell_a_mv <= OVD_MV || cell_b_mv <= OVD_MV;
   assign ocur_cmp = node_mv >= OCUR_MV;
   assign short_cmp = node_mv >= SHORT_MV;
   assign xchg_cmp = node_mv <= XCHG_MV;
   assign wake_cmp = node_mv <= WAKE_MV;
endmodule
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pda_consts.svh"

module testbench;
   typedef struct {
      logic [4:0] v; // Expected {chg, dis, pull, standby}
      logic [4:0] m; // Fields compared
      int lo; // Earliest edge
      int hi; // Latest edge
   } pda_note_t;
   logic sys_clk, rst, test_mode, standby, chg_gate, dis_gate;
   logic ovc_cmp, ovc_rel_cmp, ovd_cmp, ocur_cmp, short_cmp;
   logic xchg_cmp, wake_cmp;
   logic signed [15:0] cell_a_mv, cell_b_mv;
   logic [1:0] load_sel, chgr_sel;
   pda_pkg::pda_pull_t pull_state;
   logic [4:0] outs;
   pda_note_t notes[$]; // Pending expected changes
   int cyc = 0, seed, fail_count = 0, check_count = 0;

   assign outs = {chg_gate, dis_gate, pull_state, standby};

   pda_arbiter pda_arbiter_i (.sys_clk(sys_clk), .rst(rst),
      .test_mode(test_mode), .ovc_cmp(ovc_cmp), .ovc_rel_cmp(ovc_rel_cmp),
      .ovd_cmp(ovd_cmp), .ocur_cmp(ocur_cmp), .short_cmp(short_cmp),
      .xchg_cmp(xchg_cmp), .wake_cmp(wake_cmp), .chg_gate(chg_gate),
      .dis_gate(dis_gate), .pull_state(pull_state), .standby(standby));
   pda_pack_model pda_pack_model_i (.cell_a_mv(cell_a_mv),
      .cell_b_mv(cell_b_mv), .load_sel(load_sel), .chgr_sel(chgr_sel),
      .dis_gate(dis_gate), .pull_state(pull_state), .ovc_cmp(ovc_cmp),
      .ovc_rel_cmp(ovc_rel_cmp), .ovd_cmp(ovd_cmp), .ocur_cmp(ocur_cmp),
      .short_cmp(short_cmp), .xchg_cmp(xchg_cmp), .wake_cmp(wake_cmp));

   // Clock, 20 ns period
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // Edge counter for timing windows
   always @(posedge sys_clk) cyc <= cyc + 1;

   // Delay in cycles under the current test pin level
   function automatic int lim(int us);
      return test_mode ? (us * `PDA_CLK_MHZ) >> `PDA_TEST_SHIFT
                       : us * `PDA_CLK_MHZ;
   endfunction

   task automatic check(logic [4:0] seen, logic [4:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Note an expected output change within a window of edges
   task automatic expect_out(logic [4:0] v, logic [4:0] m, int lo, int hi);
      notes.push_back('{v, m, cyc + lo, cyc + hi});
   endtask

   task automatic cycles(int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Watcher: each output change takes the oldest note
   initial begin
      pda_note_t n;
      logic [4:0] last;
      @(negedge rst);
      @(negedge sys_clk);
      last = outs;
      forever begin
         @(negedge sys_clk);
         if (outs !== last) begin
            if (notes.size() == 0) begin
               check(outs, last); // Unexpected change
            end else begin
               n = notes.pop_front();
               check(outs & n.m, n.v & n.m);
               check({4'h0, cyc >= n.lo && cyc <= n.hi}, 5'h01);
            end
            last = outs;
         end
      end
   end

   // Stimulus, applied at falling edges
   initial begin
      int g, lovd, locr, lxc, lrel, lorl, lovc;
      seed = 79719;
      rst = 1'b1;
      test_mode = 1'b0;
      cell_a_mv = 16'h0e74;
      cell_b_mv = 16'h0e74;
      load_sel = 2'h0;
      chgr_sel = 2'h0;
      cycles(10);
      rst = 1'b0;
      cycles(2);
      // Short in normal timing, released in short timing
      load_sel = 2'h2;
      expect_out(5'h14, 5'h1f, 15000, 15005);
      cycles(15010);
      test_mode = 1'b1;
      lovd = lim(`PDA_OVD_DLY_US);
      locr = lim(`PDA_OCUR_DLY_US);
      lxc = lim(`PDA_XCHG_DLY_US);
      lrel = lim(`PDA_OVD_REL_US);
      lorl = lim(`PDA_OCUR_REL_US);
      lovc = lim(`PDA_OVC_DLY_US);
      load_sel = 2'h0;
      expect_out(5'h18, 5'h0e, lorl, lorl + 5);
      cycles(lorl + 10);
      $display("test short done");
      // Interrupted low cell, then a full detection
      g = 10 + int'($unsigned($random(seed)) % (lovd - 20));
      cell_b_mv = 16'h0960;
      cycles(g);
      cell_b_mv = 16'h0e74;
      cycles(5);
      cell_b_mv = 16'h0960;
      expect_out(5'h13, 5'h1f, lovd, lovd + 5);
      cycles(lovd + 10);
      load_sel = 2'h1;
      cycles(locr + 20);
      load_sel = 2'h0;
      chgr_sel = 2'h2;
      expect_out(5'h00, 5'h01, 1, 5);
      cycles(lxc + 20);
      cell_b_mv = 16'h0e74;
      expect_out(5'h08, 5'h08, lrel, lrel + 5);
      expect_out(5'h00, 5'h10, lrel + lxc, lrel + lxc + 10);
      cycles(lrel + lxc + 20);
      $display("test discharge done");
      // Over-charge first with low cell and load overlapping
      chgr_sel = 2'h0;
      rst = 1'b1;
      expect_out(5'h18, 5'h1f, 1, 3);
      cycles(2);
      rst = 1'b0;
      cell_a_mv = 16'h1130;
      cycles(100);
      cell_b_mv = 16'h0960;
      expect_out(5'h08, 5'h1f, lovc - 100, lovc - 94);
      cycles(lovc - 90);
      load_sel = 2'h1;
      expect_out(5'h02, 5'h1f, lovd - 10, lovd + 5);
      cycles(locr + 20);
      load_sel = 2'h0;
      cycles(lovd);
      check({4'h0, notes.size() == 0}, 5'h01);
      $display("test overlap done");
      print_verdict();
   end

   // Watchdog
   initial begin
      #1000000;
      fail_count++;
      $display("BAD t=%0t watchdog expired", $time);
      print_verdict();
   end
endmodule
`default_nettype wire
